// ===== shared/spcl_defines.svh
// register offsets, field positions, reset values and frame counts
`ifndef SPCL_DEFINES_SVH
`define SPCL_DEFINES_SVH

// =====================================================================
// register offsets (13-bit serial address space)
`define SPCL_ADDR_CFG       13'h000
`define SPCL_ADDR_ID        13'h003
`define SPCL_ADDR_BANK      13'h004

// =====================================================================
// field positions
`define SPCL_CFG_SEP_OUT    0
`define SPCL_CFG_LSB_FIRST  1
`define SPCL_CFG_SOFT_RST   2
`define SPCL_CFG_LONG_INSTR 3
`define SPCL_BANK_ACTIVE    0
`define SPCL_INSTR_RW       15
`define SPCL_INSTR_LEN_HI   14
`define SPCL_INSTR_LEN_LO   13
`define SPCL_INSTR_ADDR_HI  12

// =====================================================================
// reset values and masks
`define SPCL_CFG_RESET      8'h18
`define SPCL_BANK_RESET     8'h00
`define SPCL_BANK_MASK      8'h01
`define SPCL_VARIANT_ID     8'h5a

// =====================================================================
// frame counts
`define SPCL_INSTR_LAST     4'hf
`define SPCL_DATA_LAST      4'h7
`define SPCL_LEN_STREAM     2'h3

`endif

// ===== shared/spcl_pkg.sv
// types shared by the serial port configuration logic
package spcl_pkg;

  // =====================================================================
  // frame phase of the serial engine
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_DATA,
    PH_DONE
  } spcl_phase_t;

  // =====================================================================
  // register image, frozen while a frame is open
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] bank;
    logic [7:0] cfgAct;
    logic [7:0] bankAct;
    logic [7:0] id;
  } spcl_image_t;

  // completed serial write, announced by a toggle
  typedef struct packed {
    logic        toggle;
    logic [12:0] addr;
    logic [7:0]  data;
  } spcl_wr_t;

  // state of the system-clock register bank
  typedef struct packed {
    logic        csMeta;
    logic        csIdle;
    logic        tglMeta;
    logic        tglSync;
    logic        tglSeen;
    logic [7:0]  cfg;
    logic [7:0]  bank;
    logic [7:0]  cfgAct;
    logic [7:0]  bankAct;
    spcl_image_t image;
  } spcl_bank_t;

  // state of the serial engine on the rising serial clock
  typedef struct packed {
    spcl_phase_t phase;
    logic [3:0]  bitCnt;
    logic [15:0] instr;
    logic        isRead;
    logic        stream;
    logic [1:0]  bytesLeft;
    logic [12:0] addr;
    logic [7:0]  shreg;
  } spcl_link_t;

  // pin drivers on the falling serial clock
  typedef struct packed {
    logic sdioOut;
    logic sdioOeN;
    logic sepOut;
    logic sepOeN;
  } spcl_pins_t;

endpackage

// ===== rtl/spcl_reg_bank.sv
// buffer and active registers of the serial port, on the system clock
`timescale 1ns/1ps
`include "spcl_defines.svh"

module spcl_reg_bank (
  input  wire logic                clk_sys,      // system clock
  input  wire logic                srst,         // sync reset, high
  input  wire logic                csN,          // chip select pin
  input  wire spcl_pkg::spcl_wr_t  wr,           // write from link
  input  wire logic                updateActive, // buffer to active
  output spcl_pkg::spcl_image_t    image,        // frozen image
  output logic [7:0]               activeConfig, // active config
  output logic [7:0]               activeBank,   // active bank sel
  output logic                     softReset     // soft reset level
);
  import spcl_pkg::*;

  spcl_bank_t s;
  spcl_bank_t next_s;

  // =====================================================================
  // next state
  always_comb begin
    next_s = s;
    // two-stage synchronisers for chip select and write toggle
    next_s.csMeta  = csN;
    next_s.csIdle  = s.csMeta;
    next_s.tglMeta = wr.toggle;
    next_s.tglSync = s.tglMeta;
    // a new write event: address and data are stable by now
    if (s.tglSync != s.tglSeen) begin
      next_s.tglSeen = s.tglSync;
      case (wr.addr)
        `SPCL_ADDR_CFG:  next_s.cfg  = wr.data;
        `SPCL_ADDR_BANK: next_s.bank = wr.data & `SPCL_BANK_MASK;
        default: ;
      endcase
    end
    // copy buffers into the active set
    if (updateActive) begin
      next_s.cfgAct  = s.cfg;
      next_s.bankAct = s.bank;
    end
    // soft reset holds bank select at its default until software writes it back to 0
    if (s.cfg[`SPCL_CFG_SOFT_RST]) begin
      next_s.bank    = `SPCL_BANK_RESET;
      next_s.cfgAct  = s.cfg;
      next_s.bankAct = `SPCL_BANK_RESET;
    end
    // image follows the registers only between frames
    if (s.csIdle) begin
      next_s.image.cfg     = s.cfg;
      next_s.image.bank    = s.bank;
      next_s.image.cfgAct  = s.cfgAct;
      next_s.image.bankAct = s.bankAct;
      next_s.image.id      = `SPCL_VARIANT_ID;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s               <= '0;
      s.csMeta        <= 1'b1;
      s.csIdle        <= 1'b1;
      s.cfg           <= `SPCL_CFG_RESET;
      s.bank          <= `SPCL_BANK_RESET;
      s.cfgAct        <= `SPCL_CFG_RESET;
      s.bankAct       <= `SPCL_BANK_RESET;
      s.image.cfg     <= `SPCL_CFG_RESET;
      s.image.bank    <= `SPCL_BANK_RESET;
      s.image.cfgAct  <= `SPCL_CFG_RESET;
      s.image.bankAct <= `SPCL_BANK_RESET;
      s.image.id      <= `SPCL_VARIANT_ID;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign image        = s.image;
  assign activeConfig = s.cfgAct;
  assign activeBank   = s.bankAct;
  assign softReset    = s.cfg[`SPCL_CFG_SOFT_RST];

endmodule // spcl_reg_bank

// ===== rtl/spcl_port_config.sv
// serial control port engine and its configuration registers
`timescale 1ns/1ps
`include "spcl_defines.svh"

//
// the serial engine runs on the host's serial clock and is cleared
// whenever chip select is high. the register bank runs on clk_sys.
// writes cross as a toggle with held address and data; reads use a
// register image that the bank freezes while chip select is low.
//

// Behaviour
// - Only the 16-bit instruction is supported and the host keeps the long-instruction bit at 1.
// - A 1 in config bit 2 holds both bank select registers at their defaults, copies config into the active set and never clears itself.
// - With bit order 0 data moves most significant bit first and the address steps down.
// - With bit order 1 data moves least significant bit first and the address steps up.
// - With output select 0 the shared data pin carries reads and the separate output floats.
// - With output select 1 reads leave only on the separate output pin.
// - Address 0x003 is a read-only variant code and writes to it are ignored.
// - Bank select bit 0 makes reads return buffer registers at 0 and active ones at 1.
module spcl_port_config (
  input  wire logic  clk_sys,                    // system clock
  input  wire logic  srst,                       // sync reset, high
  input  wire logic  sclk,                       // host serial clock
  input  wire logic  csN,                        // chip select, low
  input  wire logic  sdioIn,                     // shared data in
  output logic       sdioOut,                    // shared data out
  output logic       sdioOeN,                    // shared enable, low
  output logic       separateSerialOutputPin,    // separate out
  output logic       separateSerialOutputPinOeN, // separate enable
  input  wire logic  updateActive,               // buffer to active
  output logic [7:0] activeConfig,               // active config
  output logic [7:0] activeBank,                 // active bank select
  output logic       softReset                   // soft reset level
);
  import spcl_pkg::*;

  localparam spcl_link_t LINK_IDLE = '{
    phase:     PH_INSTR,
    bitCnt:    4'h0,
    instr:     16'h0000,
    isRead:    1'b0,
    stream:    1'b0,
    bytesLeft: 2'h0,
    addr:      13'h0000,
    shreg:     8'h00
  };

  localparam spcl_pins_t PINS_IDLE = '{
    sdioOut: 1'b0,
    sdioOeN: 1'b1,
    sepOut:  1'b0,
    sepOeN:  1'b1
  };

  spcl_link_t  link;
  spcl_link_t  next_link;
  spcl_wr_t    wr;
  spcl_wr_t    next_wr;
  spcl_pins_t  pins;
  spcl_pins_t  next_pins;
  spcl_image_t image;
  logic        wrFire;
  logic        lsbFirst;
  logic        sepSel;
  logic [15:0] shiftIn16;
  logic [7:0]  shiftIn8;
  logic [12:0] stepAddr;
  logic [1:0]  lenCode;
  logic        drive;
  logic [2:0]  bitIdx;

  // =====================================================================
  // register bank on the system clock
  spcl_reg_bank u_bank (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .csN          (csN),
    .wr           (wr),
    .updateActive (updateActive),
    .image        (image),
    .activeConfig (activeConfig),
    .activeBank   (activeBank),
    .softReset    (softReset)
  );

  // =====================================================================
  // readback lookup: bank select picks buffer or active copies
  function automatic logic [7:0] readByte(
    input logic [12:0] a,
    input spcl_image_t im
  );
    logic act;
    act      = im.bank[`SPCL_BANK_ACTIVE];
    readByte = 8'h00;
    case (a)
      `SPCL_ADDR_CFG:  readByte = act ? im.cfgAct : im.cfg;
      `SPCL_ADDR_ID:   readByte = im.id;
      `SPCL_ADDR_BANK: readByte = act ? im.bankAct : im.bank;
      default:         readByte = 8'h00;
    endcase
  endfunction

  // =====================================================================
  // frame decode of the frozen configuration
  // only the lower nibble is decoded; the mirror serves the host
  always_comb begin
    lsbFirst = image.cfg[`SPCL_CFG_LSB_FIRST];
    sepSel   = image.cfg[`SPCL_CFG_SEP_OUT];
  end

  // shift paths and address stepping follow the bit order
  always_comb begin
    if (lsbFirst) begin
      shiftIn16 = {sdioIn, link.instr[15:1]};
      shiftIn8  = {sdioIn, link.shreg[7:1]};
      stepAddr  = link.addr + 13'h0001;
    end else begin
      shiftIn16 = {link.instr[14:0], sdioIn};
      shiftIn8  = {link.shreg[6:0], sdioIn};
      stepAddr  = link.addr - 13'h0001;
    end
    lenCode = shiftIn16[`SPCL_INSTR_LEN_HI:`SPCL_INSTR_LEN_LO];
  end

  // =====================================================================
  // serial engine, rising edge of the serial clock
  always_comb begin
    next_link = link;
    wrFire    = 1'b0;
    case (link.phase)
      PH_INSTR: begin
        // instruction is always 16 bits whatever bit 3 holds
        next_link.instr  = shiftIn16;
        next_link.bitCnt = link.bitCnt + 4'h1;
        if (link.bitCnt == `SPCL_INSTR_LAST) begin
          next_link.phase     = PH_DATA;
          next_link.bitCnt    = 4'h0;
          next_link.isRead    = shiftIn16[`SPCL_INSTR_RW];
          next_link.stream    = (lenCode == `SPCL_LEN_STREAM);
          next_link.bytesLeft = lenCode;
          next_link.addr      = shiftIn16[`SPCL_INSTR_ADDR_HI:0];
          next_link.shreg     = readByte(
            shiftIn16[`SPCL_INSTR_ADDR_HI:0], image);
        end
      end
      PH_DATA: begin
        next_link.bitCnt = link.bitCnt + 4'h1;
        if (!link.isRead) begin
          next_link.shreg = shiftIn8;
        end
        if (link.bitCnt == `SPCL_DATA_LAST) begin
          // byte complete: post writes, step the address
          next_link.bitCnt = 4'h0;
          next_link.addr   = stepAddr;
          wrFire           = !link.isRead;
          if (link.isRead) begin
            next_link.shreg = readByte(stepAddr, image);
          end
          if (!link.stream) begin
            if (link.bytesLeft == 2'h0) begin
              next_link.phase = PH_DONE;
            end else begin
              next_link.bytesLeft = link.bytesLeft - 2'h1;
            end
          end
        end
      end
      PH_DONE: begin
        // extra clocks after the last byte are ignored
        next_link = link;
      end
      default: begin
        next_link = LINK_IDLE;
      end
    endcase
  end

  // chip select high ends the frame without any serial clock edge
  always_ff @(posedge sclk or posedge csN or posedge srst) begin
    if (csN || srst) begin
      link <= LINK_IDLE;
    end else begin
      link <= next_link;
    end
  end

  // =====================================================================
  // write hand-off: held address and data plus a toggle
  always_comb begin
    next_wr = wr;
    if (wrFire) begin
      next_wr.toggle = ~wr.toggle;
      next_wr.addr   = link.addr;
      next_wr.data   = shiftIn8;
    end
  end

  // survives chip select so the bank can still fetch the last byte
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      wr <= '0;
    end else begin
      wr <= next_wr;
    end
  end

  // =====================================================================
  // pin drivers, falling edge of the serial clock
  always_comb begin
    drive  = (link.phase == PH_DATA) && link.isRead;
    bitIdx = lsbFirst ? link.bitCnt[2:0]
                      : 3'h7 - link.bitCnt[2:0];
    next_pins.sdioOut = link.shreg[bitIdx];
    next_pins.sepOut  = link.shreg[bitIdx];
    next_pins.sdioOeN = !(drive && !sepSel);
    next_pins.sepOeN  = !(drive && sepSel);
  end

  // both data pins float whenever no frame is open
  always_ff @(negedge sclk or posedge csN or posedge srst) begin
    if (csN || srst) begin
      pins <= PINS_IDLE;
    end else begin
      pins <= next_pins;
    end
  end

  // outputs straight from flops
  assign sdioOut                    = pins.sdioOut;
  assign sdioOeN                    = pins.sdioOeN;
  assign separateSerialOutputPin    = pins.sepOut;
  assign separateSerialOutputPinOeN = pins.sepOeN;

endmodule // spcl_port_config

// ===== tb/spcl_port_config_monitor.sv
// assertions on the ports of the serial port configuration logic
`timescale 1ns/1ps
`include "spcl_defines.svh"

module spcl_port_config_monitor (
  input wire logic       clk_sys,                    // system clock
  input wire logic       srst,                       // sync reset
  input wire logic       sclk,                       // serial clock
  input wire logic       csN,                        // chip select
  input wire logic       sdioIn,                     // shared data in
  input wire logic       sdioOut,                    // shared data out
  input wire logic       sdioOeN,                    // shared enable
  input wire logic       separateSerialOutputPin,    // separate out
  input wire logic       separateSerialOutputPinOeN, // separate enable
  input wire logic       updateActive,               // buffer to active
  input wire logic [7:0] activeConfig,               // active config
  input wire logic [7:0] activeBank,                 // active bank
  input wire logic       softReset                   // soft reset level
);
  // ====================================================================
  // clocking and reset shared by every check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // pin enables
  oe_exclusive_a:
    assert property (!(!sdioOeN && !separateSerialOutputPinOeN))
    else $error("both data pins driven at once");
  cs_float_a:
    assert property (csN |-> sdioOeN && separateSerialOutputPinOeN)
    else $error("data pin driven while deselected");
  reset_float_a:
    assert property ($past(srst) |-> sdioOeN && !sdioOut)
    else $error("shared pin not released after reset");

  // register values
  reset_values_a:
    assert property ($past(srst) |-> activeConfig == `SPCL_CFG_RESET
      && activeBank == `SPCL_BANK_RESET && !softReset)
    else $error("wrong values after reset");
  bank_bits_a:
    assert property (activeBank[7:1] == 7'h00)
    else $error("unused bank select bits set");
  hold_active_a:
    assert property ((!updateActive && !softReset) ##1 !softReset
      |-> $stable(activeConfig) && $stable(activeBank))
    else $error("active registers changed without update");
  soft_bank_a:
    assert property (softReset [*2] |-> activeBank == 8'h00)
    else $error("bank select kept during soft reset");
  soft_cfg_a:
    assert property (softReset [*2] |-> activeConfig[2])
    else $error("soft reset bit cleared itself");

  // main scenarios
  cover property (!sdioOeN);
  cover property (!separateSerialOutputPinOeN);
  cover property (softReset [*2]);
endmodule // spcl_port_config_monitor

bind spcl_port_config spcl_port_config_monitor mon_u (.clk_sys, .srst,
  .sclk, .csN, .sdioIn, .sdioOut, .sdioOeN, .separateSerialOutputPin,
  .separateSerialOutputPinOeN, .updateActive, .activeConfig, .activeBank,
  .softReset);

// ===== tb/spcl_host_model.sv
// host controller model that drives the serial control port
`timescale 1ns/1ps

module spcl_host_model (
  output logic      sclk,     // serial clock, still between frames
  output logic      csN,      // chip select, low
  output logic      hostDrv,  // value the host puts on the shared pin
  output logic      hostOe,   // host drives the shared pin
  input  wire logic sdioWire, // resolved shared pin
  input  wire logic sepWire   // resolved separate pin
);
  // ====================================================================
  // idle pins
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostDrv = 1'b0;
    hostOe = 1'b1;
  end

  // one frame: instruction then n bytes, first byte in d[15:8]
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input int n, input logic lsb, input logic sep,
                      input logic [15:0] d, output logic [15:0] q);
    logic [15:0] ins;
    int          p;
    int          j;
    ins = {rd, 2'(n - 1), a};
    q = 16'h0000;
    p = 0;
    csN = 1'b0;
    #400; // select settles before the first edge
    for (int i = 0; i < 16 + 8 * n; i++) begin
      j = i - 16;
      if (i < 16) begin
        hostDrv = ins[lsb ? i : 15 - i];
      end else begin
        p = 15 - 8 * (j / 8) - (lsb ? 7 - j % 8 : j % 8);
        hostOe = !rd; // release the pin for read data
        hostDrv = d[p];
      end
      #32;
      if (i >= 16 && rd) begin
        q[p] = sep ? sepWire : sdioWire;
      end
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #32;
    csN = 1'b1;
    hostOe = 1'b1;
    #1000; // deselect gap lets a write land
  endtask
endmodule // spcl_host_model

// ===== tb/testbench.sv
// self-checking bench for the serial port configuration logic
`timescale 1ns/1ps
`include "spcl_defines.svh"

module testbench;
  logic       clk_sys;
  logic       srst;
  logic       sclk;
  logic       csN;
  logic       hostDrv;
  logic       hostOe;
  logic       sdioOut;
  logic       sdioOeN;
  logic       sepOut;
  logic       sepOeN;
  logic       updateActive;
  logic [7:0] activeConfig;
  logic [7:0] activeBank;
  logic       softReset;
  logic       lsb;
  logic       sep;
  int         err_total;
  int         samples_checked;
  // undriven pins show a pattern that moves every bit
  wire sdioWire = !sdioOeN ? sdioOut : (hostOe ? hostDrv : sclk);
  wire sepWire = !sepOeN ? sepOut : sclk;

  // ====================================================================
  // design, host and clock
  spcl_port_config dut_u (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
    .csN(csN), .sdioIn(sdioWire), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
    .separateSerialOutputPin(sepOut), .separateSerialOutputPinOeN(sepOeN),
    .updateActive(updateActive), .activeConfig(activeConfig),
    .activeBank(activeBank), .softReset(softReset));
  spcl_host_model host_u (.sclk(sclk), .csN(csN), .hostDrv(hostDrv),
    .hostOe(hostOe), .sdioWire(sdioWire), .sepWire(sepWire));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one frame; reads compare against d
  task automatic rw(input logic rd, input logic [12:0] a, input int n,
                    input logic [15:0] d);
    logic [15:0] q;
    @(negedge clk_sys);
    host_u.xfer(rd, a, n, lsb, sep, d, q);
    if (rd) begin
      chk(n == 1 ? {q[15:8], 8'h00} : q, d);
    end
  endtask

  // copy buffer registers to active
  task automatic pulse();
    @(negedge clk_sys);
    updateActive = 1'b1;
    @(negedge clk_sys);
    updateActive = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ====================================================================
  // test sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    srst = 1'b1;
    updateActive = 1'b0;
    lsb = 1'b0;
    sep = 1'b0;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(16'(activeConfig), 16'h0018);
    chk(16'({sdioOeN, sepOeN, activeBank}), 16'h0300);
    rw(1, `SPCL_ADDR_ID, 1, {`SPCL_VARIANT_ID, 8'h00});
    rw(0, `SPCL_ADDR_ID, 1, 16'ha500);
    rw(1, `SPCL_ADDR_ID, 1, {`SPCL_VARIANT_ID, 8'h00});
    rw(1, `SPCL_ADDR_CFG, 1, 16'h1800);
    rw(0, `SPCL_ADDR_BANK, 1, 16'h0100);
    chk(16'(activeBank), 16'h0000);
    rw(1, `SPCL_ADDR_BANK, 1, 16'h0000);
    pulse();
    chk(16'(activeBank), 16'h0001);
    rw(1, `SPCL_ADDR_BANK, 2, {8'h01, `SPCL_VARIANT_ID});
    rw(0, `SPCL_ADDR_CFG, 1, 16'hdb00);
    lsb = 1'b1;
    sep = 1'b1;
    rw(1, `SPCL_ADDR_ID, 2, {`SPCL_VARIANT_ID, 8'h01});
    rw(1, `SPCL_ADDR_CFG, 1, 16'h1800);
    pulse();
    chk(16'(activeConfig), 16'h00db);
    rw(1, `SPCL_ADDR_CFG, 1, 16'hdb00);
    rw(0, `SPCL_ADDR_CFG, 1, 16'hff00);
    chk(16'({softReset, activeBank}), 16'h0100);
    rw(1, `SPCL_ADDR_BANK, 1, 16'h0000);
    rw(0, `SPCL_ADDR_CFG, 1, 16'hdb00);
    chk(16'(softReset), 16'h0000);
    pulse();
    chk({activeConfig, activeBank}, 16'hdb00);
    test_done();
  end

  // watchdog against a hung frame
  initial begin
    #500000;
    err_total++;
    test_done();
  end
endmodule // testbench
